// *** brs_apb_master.sv ***
// Processor-side APB master model for the banked register space
`timescale 1ns/1ps
`default_nettype none
module brs_apb_master
  import brs_pkg::*;
(
  // Clock
  input  wire logic                  clk,
  // APB request
  output logic                       psel,
  output logic                       penable,
  output logic                       pwrite,
  output logic      [BRS_ADDR_W-1:0] paddr,
  output logic      [31:0]           pwdata,
  // APB answer
  input  wire logic [31:0]           prdata,
  input  wire logic                  pready,
  input  wire logic                  pslverr
);
  // Bus idle from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
  end
  // One transfer; request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [BRS_ADDR_W-1:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d}; // Unused upper lanes always zero
    @(posedge clk);
    penable <= 1'b1;
    // No latency assumed; the bench timeout cuts a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** brs_banked_regs.sv ***
// Two-bank byte register space behind an APB slave
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Flag register decodes at F7h in both banks
// - Bank select never gates shared registers
// - Two banks; non-shared offsets differ per bank
// - Registers marked 00 clear on reset
// - Registers marked XX keep contents through reset
// - Read-only bits read back, ignore writes
// - Write-only bits accept writes, read zero
// - Clearable bits read back, clear by write
module brs_banked_regs
  import brs_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [BRS_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Pins from the USB front end, asynchronous
  input  wire logic                  usbActivityPin,
  input  wire logic                  usbEventPin,
  // Configuration seen by the rest of the chip
  output logic                       bankSelectFlag,
  output logic      [7:0]            spiConfig,
  output logic      [7:0]            mainOscTrim,
  output logic      [7:0]            lowOscTrim,
  output logic      [7:0]            mainOscTrimFine
);

  logic [7:0]  idx;
  brs_dec_t    dec;
  logic        wrFire;
  logic        rdTake;
  logic [7:0]  rdByte;
  logic [7:0]  b1Rd;
  logic [BRS_NUM_B1-1:0] b1Hit;
  logic [7:0]  cellVal [BRS_NUM_B1];
  logic [7:0]  cellRd  [BRS_NUM_B1];
  logic [7:0]  bank0Mem [256];
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;
  logic [7:0]  flags_reg;
  logic        usbEn_reg;
  logic        usbEvt_reg;
  logic        usbEvt_next;
  logic        actSync1_reg;
  logic        actSync2_reg;
  logic        evtSync1_reg;
  logic        evtSync2_reg;
  logic        evtPrev_reg;
  logic        evtRise;

  // Address decode; the flag register is checked before the bank bit
  always_comb begin
    idx        = paddr[BRS_IDX_LSB +: 8];
    dec        = '0;
    dec.addrOk = (paddr[BRS_ADDR_W-1:BRS_IDX_LSB+8] == '0);
    dec.shared = (idx == BRS_OFF_CPU_FLAGS);
    dec.bank1  = flags_reg[BRS_FLAG_BANK_BIT] && !dec.shared;
    dec.usb    = dec.bank1 && (idx == BRS_OFF_USB_CTRL_1);
    dec.b1Any  = dec.bank1 && (|b1Hit);
    if (!dec.addrOk) begin
      dec.mapped = 1'b0;
    end else if (dec.shared) begin
      dec.mapped = 1'b1;
    end else if (dec.bank1) begin
      dec.mapped = dec.usb || dec.b1Any;
    end else begin
      dec.mapped = 1'b1;
    end
  end

  // Read data is sampled in the first access cycle, writes land on the second
  assign rdTake = psel && penable && !pready_reg;
  assign wrFire = psel && penable && pready_reg && pwrite && !pslverr_reg;

  // Bank 1 plain registers, one cell per documented offset
  genvar gi;
  generate
    for (gi = 0; gi < BRS_NUM_B1; gi++) begin : g_b1
      assign b1Hit[gi] = (idx == BRS_B1_OFFS[gi]);
      brs_byte_reg #(
        .NO_RESET   (BRS_B1_NORST[gi]),
        .WRITE_ONLY (BRS_B1_WO[gi])
      ) u_cell (
        .clk      (clk),
        .srst     (srst),
        .wrEn     (wrFire && dec.bank1 && b1Hit[gi]),
        .wrData   (pwdata[7:0]),
        .value    (cellVal[gi]),
        .readBack (cellRd[gi])
      );
    end
  endgenerate

  // Offsets are unique, so an OR of the hit cells is a clean mux
  always_comb begin
    b1Rd = BRS_RST_ZERO;
    for (int i = 0; i < BRS_NUM_B1; i++) begin
      if (b1Hit[i]) begin
        b1Rd = b1Rd | cellRd[i];
      end
    end
  end

  // Bank 0 store; never reset, and the shared offset never lands here
  always_ff @(posedge clk) begin
    if (wrFire && !dec.bank1 && !dec.shared) begin
      bank0Mem[idx] <= pwdata[7:0];
    end
  end

  // Flag register: only the enable and bank bits are writable
  always_ff @(posedge clk) begin
    if (srst) begin
      flags_reg <= BRS_RST_ZERO;
    end else if (wrFire && dec.shared) begin
      flags_reg <= pwdata[7:0] & BRS_FLAG_WMASK; // Reserved bits stay zero
    end
  end

  // Two-flop synchronisers for the USB pins
  always_ff @(posedge clk) begin
    if (srst) begin
      actSync1_reg <= 1'b0;
      actSync2_reg <= 1'b0;
      evtSync1_reg <= 1'b0;
      evtSync2_reg <= 1'b0;
      evtPrev_reg  <= 1'b0;
    end else begin
      actSync1_reg <= usbActivityPin;
      actSync2_reg <= actSync1_reg;
      evtSync1_reg <= usbEventPin;
      evtSync2_reg <= evtSync1_reg;
      evtPrev_reg  <= evtSync2_reg;
    end
  end

  // Edge detect looks only at synchronised flops
  assign evtRise = evtSync2_reg && !evtPrev_reg;

  // Event flag: writing zero clears it, a new event in that cycle wins
  always_comb begin
    usbEvt_next = usbEvt_reg;
    if (wrFire && dec.usb && !pwdata[BRS_USB_EVT_BIT]) begin
      usbEvt_next = 1'b0;
    end
    if (evtRise) begin
      usbEvt_next = 1'b1;
    end
  end

  // USB control: enable is plain storage, event is clear-only from the bus
  always_ff @(posedge clk) begin
    if (srst) begin
      usbEn_reg  <= 1'b0;
      usbEvt_reg <= 1'b0;
    end else begin
      usbEvt_reg <= usbEvt_next;
      if (wrFire && dec.usb) begin
        usbEn_reg <= pwdata[BRS_USB_EN_BIT];
      end
    end
  end

  // Read mux; the activity bit is live state and has no storage to write
  always_comb begin
    rdByte = BRS_RST_ZERO;
    if (!dec.mapped) begin
      rdByte = BRS_RST_ZERO;
    end else if (dec.shared) begin
      rdByte = flags_reg;
    end else if (dec.usb) begin
      rdByte[BRS_USB_ACT_BIT] = actSync2_reg;
      rdByte[BRS_USB_EVT_BIT] = usbEvt_reg;
      rdByte[BRS_USB_EN_BIT]  = usbEn_reg;
    end else if (dec.bank1) begin
      rdByte = b1Rd;
    end else begin
      rdByte = bank0Mem[idx];
    end
  end

  // APB answer: one wait state keeps every bus output on a flop
  always_ff @(posedge clk) begin
    if (srst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= rdTake;
      pslverr_reg <= rdTake && !dec.mapped;
    end
  end

  // Read data held from the sampling edge until the next access
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata_reg <= BRS_RDATA_RST;
    end else if (rdTake) begin
      prdata_reg <= {24'h00_0000, rdByte};
    end
  end

  assign prdata          = prdata_reg;
  assign pready          = pready_reg;
  assign pslverr         = pslverr_reg;
  assign bankSelectFlag  = flags_reg[BRS_FLAG_BANK_BIT];
  assign spiConfig       = cellVal[BRS_SLOT_SPI];
  assign mainOscTrim     = cellVal[BRS_SLOT_MAIN_TRIM];
  assign lowOscTrim      = cellVal[BRS_SLOT_LOW_TRIM];
  assign mainOscTrimFine = cellVal[BRS_SLOT_TRIM_FINE];

  // Checks on the decode and register behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_ready_pulse: assert property (
    psel && penable && !pready_reg |=> pready_reg ##1 !pready_reg)
    else $error("pready not a single cycle after one wait");

  a_shared_flags: assert property (
    wrFire && idx == BRS_OFF_CPU_FLAGS
    |=> flags_reg == ($past(pwdata[7:0]) & BRS_FLAG_WMASK))
    else $error("flag register write lost");

  a_shared_any_bank: assert property (
    rdTake && idx == BRS_OFF_CPU_FLAGS && dec.addrOk
    |=> !pslverr_reg && prdata_reg[7:0] == $past(flags_reg))
    else $error("flag register not readable in this bank");

  a_bank_route: assert property (
    wrFire && flags_reg[BRS_FLAG_BANK_BIT] && idx == BRS_OFF_SPI_CONFIG
    |=> spiConfig == $past(pwdata[7:0]))
    else $error("bank 1 write not routed");

  a_bank_separate: assert property (
    wrFire && !flags_reg[BRS_FLAG_BANK_BIT] && idx == BRS_OFF_SPI_CONFIG
    |=> spiConfig == $past(spiConfig))
    else $error("bank 0 write reached bank 1");

  a_flag_reset: assert property (@(posedge clk) disable iff (1'b0)
    srst |=> flags_reg == BRS_RST_ZERO && !usbEvt_reg && !usbEn_reg)
    else $error("flags not cleared by reset");

  a_ro_activity: assert property (
    rdTake && dec.usb |=> prdata_reg[BRS_USB_ACT_BIT] == $past(actSync2_reg))
    else $error("activity bit read wrong");

  a_flag_ro_bits: assert property (
    ##1 (flags_reg & ~BRS_FLAG_WMASK) == BRS_RST_ZERO)
    else $error("read-only flag bit changed");

  a_wo_read_zero: assert property (
    rdTake && dec.bank1 && idx == BRS_OFF_MAIN_TRIM
    |=> prdata_reg[7:0] == BRS_RST_ZERO)
    else $error("write-only trim readable");

  a_clear_event: assert property (
    wrFire && dec.usb && !pwdata[BRS_USB_EVT_BIT] && !evtRise |=> !usbEvt_reg)
    else $error("event flag not cleared");

  a_event_set_wins: assert property (
    evtRise |=> usbEvt_reg)
    else $error("event lost against clear");

  a_unmapped_err: assert property (
    rdTake && !dec.mapped |=> pslverr_reg && pready_reg && prdata_reg == BRS_RDATA_RST)
    else $error("unmapped access not flagged");

  c_bank1_write:  cover property (wrFire && dec.b1Any);
  c_shared_bank1: cover property (wrFire && dec.shared && flags_reg[BRS_FLAG_BANK_BIT]);
  c_event_clear:  cover property (usbEvt_reg ##[1:20] !usbEvt_reg);
  c_unmapped:     cover property (pslverr_reg && pready_reg);

endmodule
`default_nettype wire

// *** brs_byte_reg.sv ***
// One byte-wide register cell with optional reset and optional write-only read
`timescale 1ns/1ps
`default_nettype none
module brs_byte_reg
  import brs_pkg::*;
#(
  parameter bit NO_RESET   = 1'b0,
  parameter bit WRITE_ONLY = 1'b0
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Write port
  input  wire logic       wrEn,
  input  wire logic [7:0] wrData,
  // Stored value and read-back
  output logic      [7:0] value,
  output logic      [7:0] readBack
);

  logic [7:0] store_reg;

  generate
    if (NO_RESET) begin : g_keep
      // Contents survive reset, so nothing but a write loads it
      always_ff @(posedge clk) begin
        if (wrEn) begin
          store_reg <= wrData;
        end
      end
      a_keep_reset: assert property (@(posedge clk) disable iff (1'b0)
        srst && !wrEn |=> $stable(store_reg))
        else $error("unreset register changed during reset");
    end else begin : g_clear
      // Cleared by reset
      always_ff @(posedge clk) begin
        if (srst) begin
          store_reg <= BRS_RST_ZERO;
        end else if (wrEn) begin
          store_reg <= wrData;
        end
      end
      a_clear_reset: assert property (@(posedge clk) disable iff (1'b0)
        srst |=> store_reg == BRS_RST_ZERO)
        else $error("register not cleared by reset");
    end
  endgenerate

  // Write-only cells hide their contents from the bus
  assign value    = store_reg;
  assign readBack = WRITE_ONLY ? BRS_RST_ZERO : store_reg;

endmodule
`default_nettype wire

// *** brs_pkg.sv ***
// Constants, register map and decode types for the banked register space
package brs_pkg;

  // APB geometry: one 8-bit register per aligned 32-bit word
  localparam int          BRS_ADDR_W  = 12;
  localparam int          BRS_IDX_LSB = 2;
  localparam int          BRS_NUM_B1  = 24;

  // Register indices (byte address is four times the index)
  localparam logic [7:0]  BRS_OFF_SPI_CONFIG   = 8'h28;
  localparam logic [7:0]  BRS_OFF_USB_CTRL_1   = 8'h30;
  localparam logic [7:0]  BRS_OFF_PM_WR_0      = 8'h33;
  localparam logic [7:0]  BRS_OFF_PM_WR_1      = 8'h35;
  localparam logic [7:0]  BRS_OFF_PM_WR_2      = 8'h36;
  localparam logic [7:0]  BRS_OFF_PM_WR_3      = 8'h37;
  localparam logic [7:0]  BRS_OFF_PM_WR_4      = 8'h38;
  localparam logic [7:0]  BRS_OFF_PM_WR_5      = 8'h39;
  localparam logic [7:0]  BRS_OFF_PM_WR_6      = 8'h3a;
  localparam logic [7:0]  BRS_OFF_PM_WR_7      = 8'h3b;
  localparam logic [7:0]  BRS_OFF_PM_RD_0      = 8'h3c;
  localparam logic [7:0]  BRS_OFF_PM_RD_1      = 8'h3d;
  localparam logic [7:0]  BRS_OFF_PM_RD_2      = 8'h3e;
  localparam logic [7:0]  BRS_OFF_PM_RD_3      = 8'h3f;
  localparam logic [7:0]  BRS_OFF_SCRATCH_0    = 8'h6c;
  localparam logic [7:0]  BRS_OFF_SCRATCH_1    = 8'h6d;
  localparam logic [7:0]  BRS_OFF_SCRATCH_2    = 8'h6e;
  localparam logic [7:0]  BRS_OFF_SCRATCH_3    = 8'h6f;
  localparam logic [7:0]  BRS_OFF_USB_MISC     = 8'hbd;
  localparam logic [7:0]  BRS_OFF_MAIN_TRIM    = 8'he8;
  localparam logic [7:0]  BRS_OFF_LOW_TRIM     = 8'he9;
  localparam logic [7:0]  BRS_OFF_SLEEP_1      = 8'heb;
  localparam logic [7:0]  BRS_OFF_SLEEP_2      = 8'hec;
  localparam logic [7:0]  BRS_OFF_SLEEP_3      = 8'hed;
  localparam logic [7:0]  BRS_OFF_CPU_FLAGS    = 8'hf7;
  localparam logic [7:0]  BRS_OFF_MAIN_TRIM_FN = 8'hfa;

  // Plain bank 1 registers in slot order
  localparam logic [7:0]  BRS_B1_OFFS [BRS_NUM_B1] = '{
    BRS_OFF_SPI_CONFIG, BRS_OFF_PM_WR_0, BRS_OFF_PM_WR_1, BRS_OFF_PM_WR_2,
    BRS_OFF_PM_WR_3, BRS_OFF_PM_WR_4, BRS_OFF_PM_WR_5, BRS_OFF_PM_WR_6,
    BRS_OFF_PM_WR_7, BRS_OFF_PM_RD_0, BRS_OFF_PM_RD_1, BRS_OFF_PM_RD_2,
    BRS_OFF_PM_RD_3, BRS_OFF_SCRATCH_0, BRS_OFF_SCRATCH_1, BRS_OFF_SCRATCH_2,
    BRS_OFF_SCRATCH_3, BRS_OFF_USB_MISC, BRS_OFF_MAIN_TRIM, BRS_OFF_LOW_TRIM,
    BRS_OFF_SLEEP_1, BRS_OFF_SLEEP_2, BRS_OFF_SLEEP_3, BRS_OFF_MAIN_TRIM_FN};
  // Slots that keep their contents through reset
  localparam bit          BRS_B1_NORST [BRS_NUM_B1] = '{
    0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 0, 1, 1, 0, 0, 0, 1};
  // Slots whose contents are not readable
  localparam bit          BRS_B1_WO [BRS_NUM_B1] = '{
    0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 0, 0, 0, 0};
  localparam int          BRS_SLOT_SPI       = 0;
  localparam int          BRS_SLOT_SCRATCH_0 = 13;
  localparam int          BRS_SLOT_MAIN_TRIM = 18;
  localparam int          BRS_SLOT_LOW_TRIM  = 19;
  localparam int          BRS_SLOT_TRIM_FINE = 23;

  // Field positions and masks
  localparam int          BRS_FLAG_ENABLE_BIT = 0;
  localparam int          BRS_FLAG_BANK_BIT   = 4;
  localparam logic [7:0]  BRS_FLAG_WMASK      = 8'h11;
  localparam int          BRS_USB_EN_BIT      = 0;
  localparam int          BRS_USB_EVT_BIT     = 6;
  localparam int          BRS_USB_ACT_BIT     = 7;

  // Reset values
  localparam logic [7:0]  BRS_RST_ZERO  = 8'h00;
  localparam logic [31:0] BRS_RDATA_RST = 32'h0000_0000;

  // Decode of the current APB address
  typedef struct packed {
    logic addrOk;
    logic shared;
    logic bank1;
    logic usb;
    logic b1Any;
    logic mapped;
  } brs_dec_t;

endpackage

// *** tb.sv ***
// Self-checking bench for the banked register space
`timescale 1ns/1ps
`default_nettype none
module tb;
  import brs_pkg::*;
  logic                  clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [BRS_ADDR_W-1:0] paddr;
  logic [31:0]           pwdata, prdata;
  logic                  usbAct, usbEvt, bankSel, e;
  logic [7:0]            spiCfg, mainTrim, lowTrim, fineTrim, q;
  int                    errors, testsRun, cycles;

  brs_banked_regs brs_banked_regs_i (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .usbActivityPin(usbAct), .usbEventPin(usbEvt),
    .bankSelectFlag(bankSel), .spiConfig(spiCfg), .mainOscTrim(mainTrim),
    .lowOscTrim(lowTrim), .mainOscTrimFine(fineTrim));
  brs_apb_master brs_apb_master_i (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // Clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Byte address of a register index
  function automatic logic [BRS_ADDR_W-1:0] ad(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    testsRun++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    brs_apb_master_i.xfer(1'b1, ad(i), d, q, e);
  endtask
  task automatic rdc(input logic [7:0] i, input logic [7:0] exp);
    brs_apb_master_i.xfer(1'b0, ad(i), 8'h00, q, e);
    chk(q, exp, "read data");
    chk({7'h00, e}, 8'h00, "error flag");
    chk(prdata[31:24] | prdata[23:16] | prdata[15:8], 8'h00, "upper lanes");
  endtask
  task automatic bank(input logic b);
    wr(BRS_OFF_CPU_FLAGS, {3'h0, b, 4'h0});
  endtask
  // Reset spans two edges so both see it
  task automatic do_reset;
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
  endtask

  task automatic t_reset;
    rdc(BRS_OFF_CPU_FLAGS, 8'h00);
    chk({7'h00, bankSel}, 8'h00, "bank flag");
    bank(1'b1);
    rdc(BRS_OFF_SPI_CONFIG, 8'h00);
    chk(spiCfg, 8'h00, "spi config");
    $display("reset values done");
  endtask
  // Same offset, different storage per bank
  task automatic t_banks;
    wr(BRS_OFF_SPI_CONFIG, 8'h5a);
    bank(1'b0);
    wr(BRS_OFF_SPI_CONFIG, 8'ha5);
    rdc(BRS_OFF_SPI_CONFIG, 8'ha5);
    chk(spiCfg, 8'h5a, "spi config");
    bank(1'b1);
    rdc(BRS_OFF_SPI_CONFIG, 8'h5a);
    $display("bank routing done");
  endtask
  // Flags reachable from both banks; reserved bits set on purpose
  task automatic t_shared;
    rdc(BRS_OFF_CPU_FLAGS, 8'h10);
    wr(BRS_OFF_CPU_FLAGS, 8'hff);
    rdc(BRS_OFF_CPU_FLAGS, 8'h11);
    wr(BRS_OFF_CPU_FLAGS, 8'h01);
    rdc(BRS_OFF_CPU_FLAGS, 8'h01);
    chk({7'h00, bankSel}, 8'h00, "bank flag");
    bank(1'b1);
    $display("shared flags done");
  endtask
  task automatic t_wo;
    wr(BRS_OFF_MAIN_TRIM, 8'h3c);
    wr(BRS_OFF_LOW_TRIM, 8'hc3);
    rdc(BRS_OFF_MAIN_TRIM, 8'h00);
    rdc(BRS_OFF_LOW_TRIM, 8'h00);
    chk(mainTrim, 8'h3c, "main trim");
    chk(lowTrim, 8'hc3, "low trim");
    $display("write-only done");
  endtask
  // Mid-run reset: unreset cells must survive it
  task automatic t_keep;
    wr(BRS_OFF_SCRATCH_0, 8'h77);
    wr(BRS_OFF_MAIN_TRIM_FN, 8'h96);
    do_reset;
    chk(spiCfg, 8'h00, "spi config");
    bank(1'b1);
    rdc(BRS_OFF_SCRATCH_0, 8'h77);
    rdc(BRS_OFF_MAIN_TRIM_FN, 8'h96);
    chk(mainTrim, 8'h3c, "main trim");
    chk(fineTrim, 8'h96, "fine trim");
    $display("reset keep done");
  endtask
  // Sticky event, read-only activity bit, clear by writing zero
  task automatic t_usb;
    usbAct <= 1'b1;
    repeat (2) @(posedge clk);
    usbEvt <= 1'b1;
    repeat (8) @(posedge clk);
    usbEvt <= 1'b0;
    rdc(BRS_OFF_USB_CTRL_1, 8'hc0);
    wr(BRS_OFF_USB_CTRL_1, 8'h7f);
    rdc(BRS_OFF_USB_CTRL_1, 8'hc1);
    wr(BRS_OFF_USB_CTRL_1, 8'h01);
    rdc(BRS_OFF_USB_CTRL_1, 8'h81);
    $display("usb control done");
  endtask
  task automatic t_err;
    brs_apb_master_i.xfer(1'b1, ad(8'h29), 8'h55, q, e);
    chk({7'h00, e}, 8'h01, "unmapped flag");
    brs_apb_master_i.xfer(1'b0, 12'h400, 8'h00, q, e);
    chk({7'h00, e}, 8'h01, "unmapped flag");
    chk(q, 8'h00, "unmapped data");
    $display("unmapped done");
  endtask

  task automatic end_of_test;
    $display("Counts: %0d compared, %0d mismatched", testsRun, errors);
    if (errors == 0 && testsRun > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard, far above the roughly 140 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      end_of_test;
    end
  end

  initial begin
    errors   = 0;
    testsRun = 0;
    cycles   = 0;
    srst     = 1'b1;
    usbAct   = 1'b0;
    usbEvt   = 1'b0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_banks;
    t_shared;
    t_wo;
    t_keep;
    t_usb;
    t_err;
    end_of_test;
  end
endmodule
`default_nettype wire
